// [rtl/pmsa_pkg.sv]
// Purpose: Shared constants for the program flash self-access block
// Assumes: 8-bit register port, 14-bit program words, 100 MHz clock
// Notes: Offsets are word indices on the plain register port
package pmsa_pkg;
    // Register offsets on the plain port
    localparam logic [2:0] OFS_CONTROL = 3'h0;
    localparam logic [2:0] OFS_UNLOCK = 3'h1;
    localparam logic [2:0] OFS_DATA_LOW = 3'h2;
    localparam logic [2:0] OFS_DATA_HIGH = 3'h3;
    localparam logic [2:0] OFS_ADDR_LOW = 3'h4;
    localparam logic [2:0] OFS_ADDR_HIGH = 3'h5;
    // Control register bit positions
    localparam int BIT_READ_START = 0;
    localparam int BIT_WRITE_START = 1;
    localparam int BIT_WRITE_PERMIT = 2;
    localparam int BIT_WRITE_BLOCKED = 3;
    // Widths
    localparam int WORD_W = 14;
    localparam int ADDR_W = 13;
    localparam int IMPL_W = 11;
    localparam int ROW_WORDS = 4;
    localparam logic [ADDR_W-1:0] LAST_WORD = 13'h07FF;
    // Reset byte and erased word value
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [WORD_W-1:0] ERASED_WORD = 14'h3FFF;
    // Write protect field encodings
    localparam logic [1:0] WP_NONE = 2'h3;
    localparam logic [1:0] WP_LOW_QUARTER = 2'h2;
    localparam logic [1:0] WP_LOW_HALF = 2'h1;
    // Timer: row erase plus program time
    localparam int ERASE_TIME_NS = 2000;
    localparam int PROG_TIME_NS = 2000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int ERASE_CYCLES = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TMR_W = 9;
    // Sequencer states
    typedef enum logic [1:0] {PMSA_IDLE, PMSA_READ, PMSA_ERASE, PMSA_PROG} pmsa_state_t;
endpackage

// [rtl/pmsa_if.sv]
// Purpose: Carries the write-protect decision between the two modules
// Assumes: Single clock
// Notes: Request and answer are combinational
`timescale 1ns/1ps
interface pmsa_if;
    logic [1:0] protect_field; // Write protect setting
    logic [12:0] row_addr; // Target word address
    logic allowed; // Row may be written
    modport seq (output protect_field, output row_addr, input allowed);
    modport chk (input protect_field, input row_addr, output allowed);
endinterface

// [rtl/pmsa_protect.sv]
// Purpose: Decides whether a row may be self-written
// Assumes: Protect field is static configuration
// Notes: Reads are never gated here
`timescale 1ns/1ps
module pmsa_protect (
    pmsa_if.chk pif
);
    // Quarter and half boundaries of the implemented space
    wire in_low_quarter = (pif.row_addr[12:9] == 4'h0);
    wire in_low_half = (pif.row_addr[12:10] == 3'h0);
    wire lower_blocked;
    assign lower_blocked = (pif.protect_field == pmsa_pkg::WP_LOW_QUARTER) ? in_low_quarter :
                           (pif.protect_field == pmsa_pkg::WP_LOW_HALF) ? in_low_half :
                           (pif.protect_field == pmsa_pkg::WP_NONE) ? 1'b0 : 1'b1;
    assign pif.allowed = ~lower_blocked;
endmodule // pmsa_protect

// [rtl/pmsa_top.sv]
// Purpose: Program flash self read and row write sequencer
// Assumes: Software strobes are one cycle; flash array held here
// Notes: Flash is a plain array; timer stands in for charge pump timing
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module pmsa_top (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [1:0] write_protect_field,
    input wire logic code_protect_bit,
    input wire logic ext_prog_req,
    output logic ext_prog_grant,
    output logic busy
);
    // Program flash array, 2K words
    logic [pmsa_pkg::WORD_W-1:0] flash_mem [0:(1<<pmsa_pkg::IMPL_W)-1];
    logic [7:0] progmem_addr_low_r; // Address low byte
    logic [4:0] progmem_addr_high_r; // Address high bits, 13 total
    logic [7:0] progmem_data_low_r; // Data low byte
    logic [5:0] progmem_data_high_r; // Data high bits, 14 total
    logic read_start_r; // Read in flight
    logic write_start_r; // Write in flight
    logic write_permit_bit_r; // Write permit
    logic write_blocked_r; // Last row write refused
    logic [pmsa_pkg::WORD_W-1:0] row_buf_r [0:pmsa_pkg::ROW_WORDS-1]; // Row buffer
    logic [pmsa_pkg::ADDR_W-1:0] row_addr_r; // Row latched at write start
    logic [pmsa_pkg::TMR_W-1:0] tmr_r; // Erase and program timer
    logic [1:0] word_idx_r; // Word being programmed
    logic [7:0] reg_rdata_r; // Registered read data
    pmsa_pkg::pmsa_state_t state_r;
    pmsa_pkg::pmsa_state_t state_nxt;
    pmsa_if pif();

    // Address and data pairs as words
    // 13-bit address pair
    wire [pmsa_pkg::ADDR_W-1:0] full_addr = {progmem_addr_high_r, progmem_addr_low_r};
    wire [pmsa_pkg::WORD_W-1:0] data_word = {progmem_data_high_r, progmem_data_low_r};
    wire addr_in_range = (full_addr <= pmsa_pkg::LAST_WORD);
    wire [pmsa_pkg::IMPL_W-1:0] mem_idx = full_addr[pmsa_pkg::IMPL_W-1:0];
    wire [1:0] row_slot = full_addr[1:0];
    wire hit_ctrl = (reg_addr == pmsa_pkg::OFS_CONTROL);
    wire wr_ctrl = reg_wr && hit_ctrl;
    wire idle = (state_r == pmsa_pkg::PMSA_IDLE);
    wire set_read = wr_ctrl && reg_wdata[pmsa_pkg::BIT_READ_START] && idle;
    wire set_write = wr_ctrl && reg_wdata[pmsa_pkg::BIT_WRITE_START] && idle
                     && write_permit_bit_r;
    // only the fourth word starts the cycle
    wire row_commit = set_write && (row_slot == 2'h3);
    wire buffer_only = set_write && (row_slot != 2'h3);
    // code protect plays no part in self access
    wire commit_ok = row_commit && pif.allowed && addr_in_range;
    wire tmr_done = (tmr_r == '0);

    assign pif.protect_field = write_protect_field;
    assign pif.row_addr = full_addr;
    assign busy = ~idle;
    // external programmer locked out by code protect
    assign ext_prog_grant = ext_prog_req && ~code_protect_bit;
    assign reg_rdata = reg_rdata_r;

    pmsa_protect u_protect (
        .pif(pif.chk)
    );

    // Sequencer next state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            pmsa_pkg::PMSA_IDLE: begin
                if (set_read) begin
                    state_nxt = pmsa_pkg::PMSA_READ;
                end else if (commit_ok) begin
                    state_nxt = pmsa_pkg::PMSA_ERASE;
                end
            end
            pmsa_pkg::PMSA_READ: state_nxt = pmsa_pkg::PMSA_IDLE;
            pmsa_pkg::PMSA_ERASE: begin
                if (tmr_done) begin
                    state_nxt = pmsa_pkg::PMSA_PROG;
                end
            end
            pmsa_pkg::PMSA_PROG: begin
                if (tmr_done) begin
                    state_nxt = pmsa_pkg::PMSA_IDLE;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_r <= pmsa_pkg::PMSA_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tmr_r <= '0;
        end else if (idle && commit_ok) begin
            tmr_r <= pmsa_pkg::TMR_W'(pmsa_pkg::ERASE_CYCLES - 1);
        end else if (state_r == pmsa_pkg::PMSA_ERASE && tmr_done) begin
            tmr_r <= pmsa_pkg::TMR_W'(pmsa_pkg::PROG_CYCLES - 1);
        end else if (!tmr_done) begin
            tmr_r <= tmr_r - 1'b1;
        end
    end

    // Start bits: set by software, cleared by hardware only
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            read_start_r <= 1'b0;
            write_start_r <= 1'b0;
        end else begin
            read_start_r <= set_read || (read_start_r && state_r != pmsa_pkg::PMSA_READ);
            write_start_r <= commit_ok ||
                             (write_start_r && !(state_r == pmsa_pkg::PMSA_PROG && tmr_done));
        end
    end

    // Permit and refusal flags
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            write_permit_bit_r <= 1'b0;
            write_blocked_r <= 1'b0;
        end else if (wr_ctrl) begin
            write_permit_bit_r <= reg_wdata[pmsa_pkg::BIT_WRITE_PERMIT];
            // refusal is the set, so it wins over clear
            write_blocked_r <= (row_commit && !commit_ok) ||
                               reg_wdata[pmsa_pkg::BIT_WRITE_BLOCKED];
        end
    end

    // address bytes written separately; 13 bits kept
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            progmem_addr_low_r <= pmsa_pkg::RST_BYTE;
            progmem_addr_high_r <= 5'h00;
        end else if (reg_wr && idle) begin
            if (reg_addr == pmsa_pkg::OFS_ADDR_LOW) begin
                progmem_addr_low_r <= reg_wdata;
            end
            if (reg_addr == pmsa_pkg::OFS_ADDR_HIGH) begin
                progmem_addr_high_r <= reg_wdata[4:0];
            end
        end
    end

    // data pair; read loads one word
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            progmem_data_low_r <= pmsa_pkg::RST_BYTE;
            progmem_data_high_r <= 6'h00;
        end else if (state_r == pmsa_pkg::PMSA_READ) begin
            progmem_data_low_r <= addr_in_range ? flash_mem[mem_idx][7:0] : 8'h00;
            progmem_data_high_r <= addr_in_range ? flash_mem[mem_idx][13:8] : 6'h00;
        end else if (reg_wr && idle) begin
            if (reg_addr == pmsa_pkg::OFS_DATA_LOW) begin
                progmem_data_low_r <= reg_wdata;
            end
            if (reg_addr == pmsa_pkg::OFS_DATA_HIGH) begin
                progmem_data_high_r <= reg_wdata[5:0];
            end
        end
    end

    // row buffer fills slot by slot
    always_ff @(posedge clk_sys) begin
        if (buffer_only || row_commit) begin
            row_buf_r[row_slot] <= data_word;
        end
    end

    // Row address and programming index
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            row_addr_r <= '0;
            word_idx_r <= 2'h0;
        end else if (idle && commit_ok) begin
            row_addr_r <= {full_addr[pmsa_pkg::ADDR_W-1:2], 2'h0};
            word_idx_r <= 2'h0;
        end else if (state_r == pmsa_pkg::PMSA_PROG) begin
            word_idx_r <= word_idx_r + 2'h1;
        end
    end

    // array update: erase row, then write four words at end of program
    always_ff @(posedge clk_sys) begin
        if (state_r == pmsa_pkg::PMSA_ERASE && tmr_done) begin
            for (int i = 0; i < pmsa_pkg::ROW_WORDS; i++) begin
                flash_mem[row_addr_r[pmsa_pkg::IMPL_W-1:0] + pmsa_pkg::IMPL_W'(i)] <=
                    pmsa_pkg::ERASED_WORD;
            end
        end else if (state_r == pmsa_pkg::PMSA_PROG && tmr_done) begin
            for (int i = 0; i < pmsa_pkg::ROW_WORDS; i++) begin
                flash_mem[row_addr_r[pmsa_pkg::IMPL_W-1:0] + pmsa_pkg::IMPL_W'(i)] <=
                    row_buf_r[i];
            end
        end
    end

    // register read mux; unlock reads zero
    wire [7:0] ctrl_view = {4'h0, write_blocked_r, write_permit_bit_r,
                            write_start_r, read_start_r};
    wire [7:0] rd_mux = (reg_addr == pmsa_pkg::OFS_CONTROL) ? ctrl_view :
                        (reg_addr == pmsa_pkg::OFS_DATA_LOW) ? progmem_data_low_r :
                        (reg_addr == pmsa_pkg::OFS_DATA_HIGH) ? {2'h0, progmem_data_high_r} :
                        (reg_addr == pmsa_pkg::OFS_ADDR_LOW) ? progmem_addr_low_r :
                        (reg_addr == pmsa_pkg::OFS_ADDR_HIGH) ? {3'h0, progmem_addr_high_r} :
                        8'h00;

    // Read data stands the cycle after the strobe only
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_rdata_r <= 8'h00;
        end else begin
            reg_rdata_r <= reg_rd ? rd_mux : 8'h00;
        end
    end
endmodule // pmsa_top

// [verification/pmsa_top_properties.sv]
// Purpose: Port-level checks for the flash self-access block
// Assumes: One clock, reset active high
// Notes: Bound to the top module from the bench top file
`timescale 1ns/1ps
module pmsa_top_chk (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [1:0] write_protect_field,
    input wire logic code_protect_bit,
    input wire logic ext_prog_req,
    input wire logic ext_prog_grant,
    input wire logic busy
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Cycles seen busy; a counter, since 400 is past any repetition
    logic [9:0] blen_r;
    always_ff @(posedge clk_sys or posedge rst)
        if (rst) blen_r <= 10'h000;
        else blen_r <= busy ? blen_r + 10'h001 : 10'h000;
    // Accepted control write
    wire ctrl_wr = reg_wr && reg_addr == pmsa_pkg::OFS_CONTROL && !busy;
    grant_gate_a: assert property (ext_prog_grant == (ext_prog_req && !code_protect_bit))
        else $error("programmer grant wrong");
    unlock_zero_a: assert property (reg_rd && reg_addr == pmsa_pkg::OFS_UNLOCK |=> reg_rdata == 8'h00)
        else $error("unlock register not zero");
    read_pulse_a: assert property (ctrl_wr && reg_wdata[1:0] == 2'h1 |=> busy ##1 !busy)
        else $error("read not one busy cycle");
    write_min_a: assert property ($fell(busy) |-> blen_r == 10'h001 || blen_r >= 10'h190)
        else $error("write ended early");
    write_max_a: assert property (blen_r <= 10'h1A4)
        else $error("write too long");
    protect_all_a: assert property (ctrl_wr && reg_wdata[1:0] == 2'h2 && write_protect_field == 2'h0 |=> !busy)
        else $error("protected write started");
    busy_bits_a: assert property (reg_rd && reg_addr == pmsa_pkg::OFS_CONTROL && busy |=> reg_rdata[1:0] != 2'h0)
        else $error("start bit cleared while busy");
    addr_width_a: assert property (reg_rd && reg_addr == pmsa_pkg::OFS_ADDR_HIGH |=> reg_rdata[7:5] == 3'h0)
        else $error("address high too wide");
    cover property (ctrl_wr && reg_wdata[1:0] == 2'h1);
    cover property ($fell(busy) && blen_r >= 10'h190);
    cover property (ctrl_wr && reg_wdata[1] && write_protect_field == 2'h0);
endmodule // pmsa_top_chk

// [verification/pmsa_cpu_model.sv]
// Purpose: Processor side, driving the register port
// Assumes: Tasks are entered just after a rising edge
// Notes: Unlock bytes are arbitrary; the block checks none
`timescale 1ns/1ps
module pmsa_cpu_model (
    input wire logic clk_sys,
    output logic [2:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    initial {reg_addr, reg_wdata, reg_wr, reg_rd} = 13'h0000;
    // Write strobe, then one idle edge; data inverted once released
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
        @(posedge clk_sys);
    endtask
    // Read strobe; answer stands in the next cycle only
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge clk_sys);
    endtask
    // Address, high byte first
    task automatic point(input logic [12:0] a);
        wr(pmsa_pkg::OFS_ADDR_HIGH, {3'h0, a[12:8]});
        wr(pmsa_pkg::OFS_ADDR_LOW, a[7:0]);
    endtask
    // One word, unlock pair, then the control byte
    task automatic put(input logic [12:0] a, input logic [13:0] w, input logic [7:0] c);
        point(a);
        wr(pmsa_pkg::OFS_DATA_LOW, w[7:0]);
        wr(pmsa_pkg::OFS_DATA_HIGH, {2'h0, w[13:8]});
        wr(pmsa_pkg::OFS_UNLOCK, 8'h5A);
        wr(pmsa_pkg::OFS_UNLOCK, 8'hA5);
        wr(pmsa_pkg::OFS_CONTROL, c);
    endtask
    // Single word fetch; the read finishes before the data reads
    task automatic get(input logic [12:0] a, output logic [13:0] w);
        logic [7:0] lo, hi;
        point(a);
        wr(pmsa_pkg::OFS_CONTROL, 8'h01);
        rd(pmsa_pkg::OFS_DATA_LOW, lo);
        rd(pmsa_pkg::OFS_DATA_HIGH, hi);
        w = {hi[5:0], lo};
    endtask
endmodule // pmsa_cpu_model

// [verification/pmsa_top_tb.sv]
// Purpose: Self-checking bench for the flash self-access block
// Assumes: 100 MHz clock, reset held 16 cycles
// Notes: A shadow of written words gives the expected reads
`timescale 1ns/1ps
module pmsa_top_tb;
    logic clk_sys, rst, code_protect_bit, ext_prog_req, ext_prog_grant, busy, reg_wr, reg_rd;
    logic [1:0] write_protect_field;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, b;
    logic [12:0] a0;
    logic [13:0] w;
    logic [13:0] shadow [logic [12:0]];
    int num_errors = 0, checks = 0, cyc = 0, n, seed;
    pmsa_top DUT (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .write_protect_field, .code_protect_bit, .ext_prog_req, .ext_prog_grant, .busy);
    pmsa_cpu_model cpu (.clk_sys, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic close_out;
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Hang guard, well above the expected run
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 40000) begin
            num_errors++;
            close_out();
        end
    end
    // Which of three rows each protect setting lets through
    function automatic logic allow(input int f, input int j);
        return f == 3 || (f == 2 && j > 0) || (f == 1 && j == 2);
    endfunction
    // Four random words to one row; commit or refusal expected
    task automatic row(input logic [12:0] a, input logic ok);
        logic [13:0] d [4];
        cpu.wr(pmsa_pkg::OFS_CONTROL, 8'h04);
        for (int i = 0; i < 4; i++) begin
            d[i] = 14'($random(seed));
            cpu.put(a + 13'(i), d[i], 8'h06);
        end
        if (ok) begin
            cpu.wr(pmsa_pkg::OFS_CONTROL, 8'h00);
            cpu.rd(pmsa_pkg::OFS_CONTROL, b);
            chk(b[1], 1'b1);
        end
        n = 0;
        while (busy === 1'b1 && n < 1000) begin
            @(posedge clk_sys);
            n++;
        end
        chk(n >= 380 && n < 999, ok);
        cpu.rd(pmsa_pkg::OFS_CONTROL, b);
        chk({b[3], b[1:0]}, {!ok, 2'h0});
        if (ok) for (int i = 0; i < 4; i++) shadow[a + 13'(i)] = d[i];
    endtask
    initial begin
        seed = 32'hF9016FEE;
        {rst, write_protect_field, code_protect_bit, ext_prog_req} = 5'h1C;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        for (int r = 0; r < 8; r++) begin
            cpu.rd(3'(r), b);
            chk(b, 8'h00);
        end
        cpu.wr(pmsa_pkg::OFS_ADDR_HIGH, 8'hFF);
        cpu.rd(pmsa_pkg::OFS_ADDR_HIGH, b);
        chk(b, 8'h1F);
        cpu.wr(pmsa_pkg::OFS_DATA_HIGH, 8'hFF);
        cpu.rd(pmsa_pkg::OFS_DATA_HIGH, b);
        chk(b, 8'h3F);
        $display("test reset and widths done");
        a0 = 13'($random(seed)) & 13'h07FC;
        row(a0, 1'b1);
        cpu.put(a0 + 13'h0003, 14'h0000, 8'h02);
        chk(busy, 1'b0);
        row(13'h1FFC, 1'b0);
        $display("test row, permit and range done");
        code_protect_bit <= 1'b1;
        ext_prog_req <= 1'b1;
        for (int f = 0; f < 4; f++) for (int j = 0; j < 3; j++) begin
            write_protect_field <= 2'(f);
            row(13'h01FC + 13'(j * 512), allow(f, j));
        end
        chk(ext_prog_grant, 1'b0);
        code_protect_bit <= 1'b0;
        @(posedge clk_sys);
        #1 chk(ext_prog_grant, 1'b1);
        $display("test protect table done");
        foreach (shadow[k]) begin
            cpu.get(k, w);
            chk(w, shadow[k]);
        end
        $display("test readback done");
        close_out();
    end
endmodule // pmsa_top_tb
bind pmsa_top pmsa_top_chk u_chk (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .write_protect_field, .code_protect_bit, .ext_prog_req, .ext_prog_grant, .busy);
